// file: include/tone_key_pkg.sv
package tone_key_pkg;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_THRESH = 8'h04;
    localparam logic [7:0] REG_MIN_CYC = 8'h08;
    localparam logic [7:0] REG_MIN_SMP = 8'h0C;
    localparam logic [7:0] REG_DISCARD = 8'h10;
    localparam logic [7:0] REG_TUNE = 8'h14;
    localparam logic [7:0] REG_BAND_LO = 8'h18;
    localparam logic [7:0] REG_BAND_HI = 8'h1C;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_FREQ = 8'h24;
    localparam logic [7:0] REG_MEAS = 8'h28;
    localparam logic [7:0] REG_LO_FREQ = 8'h2C;

    // Control bit positions
    localparam int CTRL_VOX = 0;
    localparam int CTRL_IQ = 1;
    localparam int CTRL_BAND = 2;
    localparam int CTRL_CAT_TX = 3;

    // Threshold field positions
    localparam int RISE_LSB = 0;
    localparam int FALL_LSB = 8;

    // Reset values
    localparam logic [6:0] RISE_RESET = 7'h50;
    localparam logic [6:0] FALL_RESET = 7'h3C;
    localparam logic [7:0] MIN_CYC_RESET = 8'h01;
    localparam logic [15:0] MIN_SMP_RESET = 16'h01E0;
    localparam logic [7:0] DISCARD_RESET = 8'h01;
    localparam logic [31:0] TUNE_RESET = 32'h006BF0D0;
    localparam logic [31:0] BAND_LO_RESET = 32'h00000000;
    localparam logic [31:0] BAND_HI_RESET = 32'hFFFFFFFF;

    // Signal and frequency constants
    localparam logic [15:0] SAMPLE_RATE_HZ = 16'hBB80;
    localparam logic [31:0] IF_OFFSET_HZ = 32'h00002EE0;
    localparam logic [29:0] PCT_SCALE = 30'h00000064;
    localparam logic [29:0] FULL_SCALE = 30'h007FFFFF;
    localparam logic [5:0] DIV_STEPS = 6'h20;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'b01,
        DIV_RUN = 2'b10
    } div_state_t;

endpackage

// file: rtl/sample_buffer.sv
`timescale 1ns/1ns
`default_nettype none
module sample_buffer #(
    parameter int W = 48
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    input wire logic [W-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [W-1:0] o_out_data,
    input wire logic i_out_ready
);
    if (W < 1) begin : g_chk
        $error("sample_buffer width must be positive");
    end

    typedef struct packed {
        logic out_valid;
        logic [W-1:0] out_data;
        logic skid_valid;
        logic [W-1:0] skid_data;
        logic in_ready;
    } buf_t;

    buf_t q;
    buf_t d;

    // Output stage plus one skid entry: ready is a flop, so a stall costs no word
    always_comb begin
        d = q;
        if (!q.out_valid || i_out_ready) begin
            if (q.skid_valid) begin
                d.out_data = q.skid_data;
                d.out_valid = 1'b1;
                d.skid_valid = 1'b0;
            end else if (i_in_valid && q.in_ready) begin
                d.out_data = i_in_data;
                d.out_valid = 1'b1;
            end else begin
                d.out_valid = 1'b0;
            end
        end else if (i_in_valid && q.in_ready) begin
            d.skid_data = i_in_data;
            d.skid_valid = 1'b1;
        end
        d.in_ready = !d.skid_valid;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
            q.in_ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign o_in_ready = q.in_ready;
    assign o_out_valid = q.out_valid;
    assign o_out_data = q.out_data;
endmodule // sample_buffer
`default_nettype wire

// file: rtl/tone_key_top.sv
// Behaviour
// - Key off when peak below fall level
// - Measurement spans at least minimum cycles
// - Finish only when both minimums met
// - Measurement spans at least minimum samples
// - Slow tones stretch window to whole cycle
// - Skip configured first crossings after rise
// - IQ mode forwards raw I and Q
// - IQ mode adds 12 kHz LO offset
// - Out-of-band frequency blocks transmit keying
// - Key on when level exceeds rise
// - VOX keys transmit from audio level
`timescale 1ns/1ns
`default_nettype none
module tone_key_top #(
    parameter logic [15:0] QUIET_LIMIT = 16'h03C0
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_tx_valid,
    input wire logic [23:0] i_tx_sample,
    output logic o_tx_ready,
    input wire logic i_rx_valid,
    input wire logic [23:0] i_rx_i,
    input wire logic [23:0] i_rx_q,
    input wire logic [23:0] i_rx_audio,
    output logic o_rx_ready,
    output logic o_usb_valid,
    output logic [47:0] o_usb_data,
    input wire logic i_usb_ready,
    output logic o_tx_key,
    output logic [31:0] o_lo_freq,
    output logic o_meas_done,
    output logic [31:0] o_freq
);
    if (QUIET_LIMIT == 16'h0000) begin : g_chk
        $error("QUIET_LIMIT must be nonzero");
    end

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [5:0] awidx;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [3:0] ctrl;
        logic [6:0] rise;
        logic [6:0] fall;
        logic [7:0] min_cyc;
        logic [15:0] min_smp;
        logic [7:0] discard;
        logic [31:0] tune;
        logic [31:0] band_lo;
        logic [31:0] band_hi;
        logic tx_ready;
        logic audio_on;
        logic prev_neg;
        logic [22:0] peak;
        logic [15:0] quiet;
        logic started;
        logic [7:0] disc_left;
        logic [15:0] smp_cnt;
        logic [7:0] cyc_cnt;
        logic [7:0] meas_cyc;
        logic [15:0] meas_smp;
        tone_key_pkg::div_state_t dstate;
        logic [5:0] dcnt;
        logic [31:0] num;
        logic [15:0] rem;
        logic [31:0] freq;
        logic meas_done;
        logic [15:0] meas_count;
        logic tx_key;
        logic [31:0] lo_freq;
    } st_t;

    st_t q;
    st_t d;

    // Returns {level above percent, level below percent}
    function automatic logic [1:0] lvl_cmp(input logic [22:0] a, input logic [6:0] pct);
        logic [29:0] lhs;
        logic [29:0] rhs;
        lhs = 30'(a) * tone_key_pkg::PCT_SCALE;
        rhs = 30'(pct) * tone_key_pkg::FULL_SCALE;
        return {lhs > rhs, lhs < rhs};
    endfunction

    function automatic logic mapped(input logic [5:0] idx);
        return idx <= tone_key_pkg::REG_LO_FREQ[7:2];
    endfunction

    function automatic logic [31:0] rd_word(input st_t s, input logic [5:0] idx);
        logic [31:0] v;
        v = 32'h0;
        case (idx)
            tone_key_pkg::REG_CTRL[7:2]: v = {28'h0, s.ctrl};
            tone_key_pkg::REG_THRESH[7:2]: v = {17'h0, s.fall, 1'b0, s.rise};
            tone_key_pkg::REG_MIN_CYC[7:2]: v = {24'h0, s.min_cyc};
            tone_key_pkg::REG_MIN_SMP[7:2]: v = {16'h0, s.min_smp};
            tone_key_pkg::REG_DISCARD[7:2]: v = {24'h0, s.discard};
            tone_key_pkg::REG_TUNE[7:2]: v = s.tune;
            tone_key_pkg::REG_BAND_LO[7:2]: v = s.band_lo;
            tone_key_pkg::REG_BAND_HI[7:2]: v = s.band_hi;
            tone_key_pkg::REG_STATUS[7:2]: begin
                v = {s.meas_count, 13'h0, s.dstate == tone_key_pkg::DIV_RUN, s.audio_on, s.tx_key};
            end
            tone_key_pkg::REG_FREQ[7:2]: v = s.freq;
            tone_key_pkg::REG_MEAS[7:2]: v = {8'h0, s.meas_cyc, s.meas_smp};
            tone_key_pkg::REG_LO_FREQ[7:2]: v = s.lo_freq;
            default: v = 32'h0;
        endcase
        return v;
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Ones-complement magnitude: one LSB low for negatives, saves an adder
    logic [22:0] mag;
    logic [1:0] rise_cmp;
    logic [1:0] peak_cmp;
    logic tx_take;
    logic xing;
    logic sample_eval;
    logic fall_off;
    logic rise_on;
    logic meas_end;
    logic cyc_ok;
    logic smp_ok;
    logic meas_take;
    logic [8:0] cyc_next;
    logic [16:0] smp_next;
    logic band_oob;
    logic band_block;
    logic [47:0] buf_in;
    logic write_go;

    assign mag = i_tx_sample[23] ? ~i_tx_sample[22:0] : i_tx_sample[22:0];
    assign rise_cmp = lvl_cmp(mag, q.rise);
    assign peak_cmp = lvl_cmp(q.peak, q.fall);
    assign tx_take = i_tx_valid && q.tx_ready;
    assign xing = q.prev_neg && !i_tx_sample[23];
    assign sample_eval = xing || (q.quiet >= QUIET_LIMIT);
    assign fall_off = tx_take && q.audio_on && sample_eval && peak_cmp[0];
    assign rise_on = tx_take && !q.audio_on && rise_cmp[1];
    assign meas_end = tx_take && q.audio_on && xing && q.started && q.disc_left == 8'h00;
    assign cyc_next = {1'b0, q.cyc_cnt} + 9'h001;
    assign smp_next = {1'b0, q.smp_cnt} + 17'h00001;
    assign cyc_ok = cyc_next >= {1'b0, q.min_cyc};
    assign smp_ok = smp_next >= {1'b0, q.min_smp};
    assign meas_take = meas_end && cyc_ok && smp_ok && q.dstate == tone_key_pkg::DIV_IDLE;
    assign band_oob = (q.tune < q.band_lo) || (q.tune > q.band_hi);
    assign band_block = q.ctrl[tone_key_pkg::CTRL_BAND] && band_oob;
    assign buf_in = q.ctrl[tone_key_pkg::CTRL_IQ] ? {i_rx_i, i_rx_q} : {i_rx_audio, i_rx_audio};
    assign write_go = q.aw_got && q.w_got && !q.bvalid;

    always_comb begin
        logic [16:0] trial;
        logic [31:0] wv;
        trial = {q.rem, q.num[31]};
        wv = wmerge(rd_word(q, q.awidx), q.wdata, q.wstrb);
        d = q;
        d.meas_done = 1'b0;
        d.tx_ready = 1'b1;

        // Bus slave: address and data may arrive in either order
        if (i_awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.awidx = i_awaddr[7:2];
            d.awready = 1'b0;
        end
        if (i_wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = i_wdata;
            d.wstrb = i_wstrb;
            d.wready = 1'b0;
        end
        if (write_go) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = mapped(q.awidx) ? tone_key_pkg::RESP_OKAY : tone_key_pkg::RESP_SLVERR;
            case (q.awidx)
                tone_key_pkg::REG_CTRL[7:2]: d.ctrl = wv[3:0];
                tone_key_pkg::REG_THRESH[7:2]: begin
                    d.rise = wv[tone_key_pkg::RISE_LSB +: 7];
                    d.fall = wv[tone_key_pkg::FALL_LSB +: 7];
                end
                tone_key_pkg::REG_MIN_CYC[7:2]: d.min_cyc = wv[7:0];
                tone_key_pkg::REG_MIN_SMP[7:2]: d.min_smp = wv[15:0];
                tone_key_pkg::REG_DISCARD[7:2]: d.discard = wv[7:0];
                tone_key_pkg::REG_TUNE[7:2]: d.tune = wv;
                tone_key_pkg::REG_BAND_LO[7:2]: d.band_lo = wv;
                tone_key_pkg::REG_BAND_HI[7:2]: d.band_hi = wv;
                default: ;
            endcase
        end
        if (q.bvalid && i_bready) begin
            d.bvalid = 1'b0;
            d.awready = 1'b1;
            d.wready = 1'b1;
        end
        if (i_arvalid && q.arready) begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rdata = rd_word(q, i_araddr[7:2]);
            d.rresp = mapped(i_araddr[7:2]) ? tone_key_pkg::RESP_OKAY : tone_key_pkg::RESP_SLVERR;
        end
        if (q.rvalid && i_rready) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end

        // Key release on per-cycle peak, so a single low sample cannot drop the key
        if (tx_take) begin
            d.prev_neg = i_tx_sample[23];
            d.quiet = xing ? 16'h0000 : ((q.quiet == 16'hFFFF) ? q.quiet : q.quiet + 16'h0001);
            if (sample_eval) begin
                d.peak = mag;
                if (fall_off) begin
                    d.audio_on = 1'b0;
                end
            end else if (mag > q.peak) begin
                d.peak = mag;
            end
            if (rise_on) begin
                d.audio_on = 1'b1;
            end

            if (!q.audio_on) begin
                d.started = 1'b0;
                d.disc_left = q.discard;
            end else begin
                if (q.started && q.smp_cnt != 16'hFFFE) begin
                    d.smp_cnt = smp_next[15:0];
                end
                if (xing) begin
                    if (q.disc_left != 8'h00) begin
                        d.disc_left = q.disc_left - 8'h01;
                    end else if (!q.started) begin
                        d.started = 1'b1;
                        d.smp_cnt = 16'h0000;
                        d.cyc_cnt = 8'h00;
                    end else begin
                        // Window keeps growing until both minimums hold
                        if (q.cyc_cnt != 8'hFE) begin
                            d.cyc_cnt = cyc_next[7:0];
                        end
                        if (meas_take) begin
                            d.meas_cyc = cyc_next[7:0];
                            d.meas_smp = smp_next[15:0];
                            d.smp_cnt = 16'h0000;
                            d.cyc_cnt = 8'h00;
                            d.dstate = tone_key_pkg::DIV_RUN;
                            d.dcnt = 6'h00;
                            d.rem = 16'h0000;
                            d.num = {24'(tone_key_pkg::SAMPLE_RATE_HZ * cyc_next[7:0]), 8'h00};
                        end
                    end
                end
            end
        end

        // Restoring divider, one quotient bit a cycle, Hz with 8 fraction bits
        case (q.dstate)
            tone_key_pkg::DIV_IDLE: ;
            tone_key_pkg::DIV_RUN: begin
                if (trial >= {1'b0, q.meas_smp}) begin
                    d.rem = 16'(trial - {1'b0, q.meas_smp});
                    d.num = {q.num[30:0], 1'b1};
                end else begin
                    d.rem = trial[15:0];
                    d.num = {q.num[30:0], 1'b0};
                end
                d.dcnt = q.dcnt + 6'h01;
                if (q.dcnt == tone_key_pkg::DIV_STEPS - 6'h01) begin
                    d.dstate = tone_key_pkg::DIV_IDLE;
                    d.freq = d.num;
                    d.meas_done = 1'b1;
                    d.meas_count = q.meas_count + 16'h0001;
                end
            end
            default: d.dstate = tone_key_pkg::DIV_IDLE;
        endcase

        if (q.ctrl[tone_key_pkg::CTRL_VOX]) begin
            d.tx_key = q.audio_on && !band_block;
        end else begin
            d.tx_key = q.ctrl[tone_key_pkg::CTRL_CAT_TX] && !band_block;
        end
        d.lo_freq = q.tune + (q.ctrl[tone_key_pkg::CTRL_IQ] ? tone_key_pkg::IF_OFFSET_HZ : 32'h0);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
            q.rise <= tone_key_pkg::RISE_RESET;
            q.fall <= tone_key_pkg::FALL_RESET;
            q.min_cyc <= tone_key_pkg::MIN_CYC_RESET;
            q.min_smp <= tone_key_pkg::MIN_SMP_RESET;
            q.discard <= tone_key_pkg::DISCARD_RESET;
            q.disc_left <= tone_key_pkg::DISCARD_RESET;
            q.tune <= tone_key_pkg::TUNE_RESET;
            q.band_lo <= tone_key_pkg::BAND_LO_RESET;
            q.band_hi <= tone_key_pkg::BAND_HI_RESET;
            q.lo_freq <= tone_key_pkg::TUNE_RESET;
            q.dstate <= tone_key_pkg::DIV_IDLE;
        end else begin
            q <= d;
        end
    end

    // Receive path to the sound card; host stall back-pressures the source
    sample_buffer #(
        .W(48)
    ) u_rx_buf (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(i_rx_valid),
        .i_in_data(buf_in),
        .o_in_ready(o_rx_ready),
        .o_out_valid(o_usb_valid),
        .o_out_data(o_usb_data),
        .i_out_ready(i_usb_ready)
    );

    assign o_awready = q.awready;
    assign o_wready = q.wready;
    assign o_bvalid = q.bvalid;
    assign o_bresp = q.bresp;
    assign o_arready = q.arready;
    assign o_rvalid = q.rvalid;
    assign o_rdata = q.rdata;
    assign o_rresp = q.rresp;
    assign o_tx_ready = q.tx_ready;
    assign o_tx_key = q.tx_key;
    assign o_lo_freq = q.lo_freq;
    assign o_meas_done = q.meas_done;
    assign o_freq = q.freq;

    logic [31:0] num_chk;
    logic [47:0] prod_chk;
    assign num_chk = {24'(tone_key_pkg::SAMPLE_RATE_HZ * q.meas_cyc), 8'h00};
    assign prod_chk = 48'(q.freq) * 48'(q.meas_smp);

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    fall_drop_a: assert property (fall_off |=> !q.audio_on)
        else $error("audio keying held after peak fell below fall level");
    rise_key_a: assert property (rise_on |=> q.audio_on)
        else $error("audio keying missed a level above rise");
    cyc_min_a: assert property (meas_take |=> q.meas_cyc >= $past(q.min_cyc))
        else $error("measurement shorter than minimum cycles");
    smp_min_a: assert property (meas_take |=> q.meas_smp >= $past(q.min_smp))
        else $error("measurement shorter than minimum samples");
    both_met_a: assert property ($rose(q.dstate == tone_key_pkg::DIV_RUN)
                                 |-> $past(meas_end && cyc_ok && smp_ok))
        else $error("measurement finished without both minimums");
    window_grow_a: assert property (meas_end && smp_ok && !cyc_ok && q.cyc_cnt != 8'hFE
                                    |=> q.started && q.cyc_cnt == $past(q.cyc_cnt) + 8'h01)
        else $error("window not extended for slow tone");
    disc_skip_a: assert property (tx_take && q.audio_on && xing && q.disc_left != 8'h00
                                  |=> !q.started && q.disc_left == $past(q.disc_left) - 8'h01)
        else $error("initial crossing not discarded");
    rearm_a: assert property (tx_take && !q.audio_on
                              |=> !q.started && q.disc_left == $past(q.discard))
        else $error("discard counter not re-armed while idle");
    iq_pass_a: assert property (q.ctrl[tone_key_pkg::CTRL_IQ] |-> buf_in == {i_rx_i, i_rx_q})
        else $error("IQ mode does not forward raw channels");
    lo_off_a: assert property (q.ctrl[tone_key_pkg::CTRL_IQ]
                               |=> o_lo_freq == $past(q.tune) + tone_key_pkg::IF_OFFSET_HZ)
        else $error("IQ mode LO lacks IF offset");
    band_stop_a: assert property (band_block |=> !o_tx_key)
        else $error("transmit keyed outside permitted band");
    vox_key_a: assert property (q.ctrl[tone_key_pkg::CTRL_VOX] && q.audio_on && !band_block
                                |=> o_tx_key)
        else $error("VOX audio did not key transmit");
    div_exact_a: assert property (q.meas_done |-> prod_chk <= 48'(num_chk)
                                  && prod_chk + 48'(q.meas_smp) > 48'(num_chk))
        else $error("frequency quotient wrong");

    cover property (q.meas_done);
    cover property (rise_on ##[1:1000] fall_off);
    cover property (band_block && q.ctrl[tone_key_pkg::CTRL_CAT_TX]);
    cover property (o_usb_valid && !i_usb_ready && !o_rx_ready);
endmodule // tone_key_top
`default_nettype wire

// file: tb/test_audio_tone_measure_tx_keying.sv
`timescale 1ns/1ns
`default_nettype none
module test_audio_tone_measure_tx_keying;
    logic sys_clk, rst_n, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
    logic tx_valid, tx_ready, rx_valid, rx_ready, usb_valid, usb_ready, tx_key, meas_done, run;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, lo_freq, freq;
    logic [1:0] bresp, rresp;
    logic [23:0] tx_sample, rx_i, rx_q, rx_audio, amp;
    logic [47:0] usb_data;
    int bad_count = 0, comparisons = 0, cycles = 0;

    tone_key_top #(.QUIET_LIMIT(16'h0010)) dut (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_awvalid(awvalid), .o_awready(awready),
        .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(1'b1), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
        .i_rready(1'b1), .o_rdata(rdata), .o_rresp(rresp), .i_tx_valid(tx_valid),
        .i_tx_sample(tx_sample), .o_tx_ready(tx_ready), .i_rx_valid(rx_valid),
        .i_rx_i(rx_i), .i_rx_q(rx_q), .i_rx_audio(rx_audio), .o_rx_ready(rx_ready),
        .o_usb_valid(usb_valid), .o_usb_data(usb_data), .i_usb_ready(usb_ready),
        .o_tx_key(tx_key), .o_lo_freq(lo_freq), .o_meas_done(meas_done), .o_freq(freq));
    tone_host host (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_run(run), .i_amp(amp),
        .i_ready(tx_ready), .o_valid(tx_valid), .o_sample(tx_sample));

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Handshakes judged at the rising edge, where the slave samples them
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge sys_clk);
            ta = ta | awready;
            tw = tw | wready;
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        do @(posedge sys_clk); while (!bvalid);
        chk(bresp, tone_key_pkg::RESP_OKAY);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] resp = tone_key_pkg::RESP_OKAY);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge sys_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (!rvalid);
        chk(rdata, exp);
        chk(rresp, resp);
    endtask
    task automatic regs_check;
        rd(tone_key_pkg::REG_THRESH, 32'h00003C50);
        rd(tone_key_pkg::REG_MIN_CYC, 32'h00000001);
        rd(tone_key_pkg::REG_MIN_SMP, 32'h000001E0);
        rd(tone_key_pkg::REG_DISCARD, 32'h00000001);
        rd(8'h30, 32'h00000000, tone_key_pkg::RESP_SLVERR);
        chk(lo_freq, 32'h006BF0D0);
        chk(tx_ready, 1'b1);
        wr(tone_key_pkg::REG_CTRL, 32'h00000008);
        repeat (2) @(negedge sys_clk);
        chk(tx_key, 1'b1);
        @(posedge sys_clk);
        wr(tone_key_pkg::REG_CTRL, 32'h00000001);
        wr(tone_key_pkg::REG_MIN_SMP, 32'h00000010);
    endtask
    // 8-sample tone: 6000 Hz; discard one crossing, then 2 cycles over 16 samples
    task automatic tone_burst(input logic key_exp);
        int t;
        t = 0;
        @(posedge sys_clk);
        amp <= 24'h7A0000;
        run <= 1'b1;
        while (!meas_done && t < 3000) begin
            @(negedge sys_clk);
            t++;
            if (t == 100) chk(tx_key, key_exp);
        end
        chk(t > 1000 && t < 1400, 1'b1);
        chk(freq, 32'h00177000);
        @(posedge sys_clk);
        rd(tone_key_pkg::REG_MEAS, 32'h00020010);
    endtask
    task automatic fall_off;
        amp <= 24'h400000;
        repeat (2000) @(negedge sys_clk);
        chk(tx_key, 1'b0);
        @(posedge sys_clk);
        run <= 1'b0;
    endtask
    task automatic push(input logic [23:0] i, input logic [23:0] q, input logic [23:0] au);
        rx_i <= i;
        rx_q <= q;
        rx_audio <= au;
        rx_valid <= 1'b1;
        do @(negedge sys_clk); while (!rx_ready);
        @(posedge sys_clk);
    endtask
    task automatic pull(input logic [47:0] exp);
        do @(negedge sys_clk); while (!usb_valid);
        chk(usb_data, exp);
        @(posedge sys_clk);
    endtask
    task automatic usb_path;
        wr(tone_key_pkg::REG_CTRL, 32'h00000002);
        rd(tone_key_pkg::REG_LO_FREQ, 32'h006C1FB0);
        chk(lo_freq, 32'h006C1FB0);
        usb_ready <= 1'b0;
        push(24'h111111, 24'h222222, 24'h333333);
        push(24'h444444, 24'h555555, 24'h666666);
        rx_valid <= 1'b0;
        @(negedge sys_clk);
        chk(rx_ready, 1'b0);
        @(posedge sys_clk);
        usb_ready <= 1'b1;
        pull(48'h111111222222);
        pull(48'h444444555555);
        wr(tone_key_pkg::REG_CTRL, 32'h00000000);
        push(24'h777777, 24'h888888, 24'h999999);
        rx_valid <= 1'b0;
        pull(48'h999999999999);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        {rst_n, awvalid, wvalid, arvalid, rx_valid, run} = 6'h00;
        {awaddr, araddr, wdata, rx_i, rx_q, rx_audio, amp} = 0;
        usb_ready = 1'b1;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        regs_check();
        tone_burst(1'b1);
        fall_off();
        // Samples met before cycles: window must stretch to a second cycle
        wr(tone_key_pkg::REG_MIN_CYC, 32'h00000002);
        wr(tone_key_pkg::REG_MIN_SMP, 32'h00000008);
        tone_burst(1'b1);
        fall_off();
        wr(tone_key_pkg::REG_BAND_HI, 32'h00000000);
        wr(tone_key_pkg::REG_CTRL, 32'h00000005);
        tone_burst(1'b0);
        fall_off();
        usb_path();
        conclude();
    end
endmodule // test_audio_tone_measure_tx_keying
`default_nettype wire

// file: tb/tone_host.sv
`timescale 1ns/1ns
`default_nettype none
module tone_host (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_run,
    input wire logic [23:0] i_amp,
    input wire logic i_ready,
    output logic o_valid,
    output logic [23:0] o_sample
);
    logic [5:0] gap_q;
    logic [2:0] idx_q;
    // Samples 41 cycles apart, longer than the divider's busy time
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gap_q <= 6'h00;
            idx_q <= 3'h0;
            o_valid <= 1'b0;
            o_sample <= 24'h000000;
        end else if (o_valid) begin
            o_valid <= !i_ready;
            if (i_ready) o_sample <= ~o_sample;
        end else if (!i_run) begin
            gap_q <= 6'h00;
            idx_q <= 3'h0;
        end else if (gap_q == 6'h27) begin
            gap_q <= 6'h00;
            idx_q <= idx_q + 3'h1;
            o_valid <= 1'b1;
            // Negative half first, so a restart never opens on a rising crossing
            o_sample <= idx_q[2] ? i_amp : -i_amp;
        end else begin
            gap_q <= gap_q + 6'h01;
        end
    end
endmodule // tone_host
`default_nettype wire
